// [src/amwt_params.svh]
/*
  Constants for the asynchronous memory wait-timeout block.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef AMWT_PARAMS_SVH
`define AMWT_PARAMS_SVH

`define AMWT_NUM_CS      4
`define AMWT_CS_W        2
`define AMWT_ADDR_W      24
`define AMWT_DATA_W      32
`define AMWT_WAIT_W      8
`define AMWT_ZERO_DATA   32'h0000_0000
`define AMWT_SETUP_CYC   8'h02
`define AMWT_STROBE_CYC  8'h04
`define AMWT_ONE_CYC     8'h01

`endif

// [src/amwt_pkg.sv]
/*
  Types for the asynchronous memory wait-timeout block.
  Assumes the constants header is on the include path.
*/
`include "amwt_params.svh"

package amwt_pkg;

  typedef enum logic [1:0]
  {
    AMWT_IDLE   = 2'b00,
    AMWT_SETUP  = 2'b01,
    AMWT_STROBE = 2'b11,
    AMWT_WAITX  = 2'b10
  } amwt_state_t;

  typedef enum logic [1:0]
  {
    AMWT_KIND_ASYNC = 2'b00,
    AMWT_KIND_SDRAM = 2'b01,
    AMWT_KIND_OWN   = 2'b10
  } amwt_kind_t;

endpackage

// [src/amwt_err_if.sv]
/*
  Carrier between the access engine and the timeout error tracker.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface amwt_err_if;
  logic async_done;
  logic timed_out;
  logic sdram_done;
  logic err;

  modport engine
  (
    output async_done,
    output timed_out,
    output sdram_done,
    input  err
  );

  modport tracker
  (
    input  async_done,
    input  timed_out,
    input  sdram_done,
    output err
  );
endinterface

`default_nettype wire

// [src/amwt_err_track.sv]
/*
  Sticky timeout error flag.
  Assumes one-cycle completion pulses from the access engine.
*/
`timescale 1ns/1ps
`default_nettype none

module amwt_err_track
(
  input  wire logic    sys_clk_in,
  input  wire logic    rstn_in,
  amwt_err_if.tracker  err_if
);

  logic err_reg;
  logic err_next;

  // A timeout in the same cycle as any clearing completion wins.
  always_comb
  begin
    err_next = err_reg;
    if (err_if.async_done && !err_if.timed_out)
    begin
      err_next = 1'b0;
    end
    if (err_if.sdram_done)
    begin
      err_next = 1'b0;
    end
    if (err_if.async_done && err_if.timed_out)
    begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      err_reg <= 1'b0;
    end
    else
    begin
      err_reg <= err_next;
    end
  end

  assign err_if.err = err_reg;

endmodule

`default_nettype wire

// [src/amwt_top.sv]
/*
  Asynchronous memory side of an external memory interface with
  extended-wait timeout detection and a persistent timeout error.
  Assumes one host request at a time, held until done; the SDRAM
  path sits outside and reports completion here, own register space supplies only data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "amwt_params.svh"

module amwt_top
(
  input  wire logic                      sys_clk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      req_in,
  input  wire logic [1:0]                req_kind_in,
  input  wire logic [`AMWT_CS_W-1:0]     req_cs_in,
  input  wire logic [`AMWT_ADDR_W-1:0]   req_addr_in,
  input  wire logic [`AMWT_NUM_CS-1:0]   ext_wait_en_in,
  input  wire logic [`AMWT_WAIT_W-1:0]   max_wait_in,
  input  wire logic [`AMWT_DATA_W-1:0]   own_rdata_in,
  input  wire logic                      sdram_done_in,
  input  wire logic [`AMWT_DATA_W-1:0]   sdram_rdata_in,
  input  wire logic [`AMWT_DATA_W-1:0]   mem_data_in,
  input  wire logic                      mem_wait_in,
  output logic                           done_out,
  output logic [`AMWT_DATA_W-1:0]        rdata_out,
  output logic                           timeout_err_out,
  output logic [`AMWT_NUM_CS-1:0]        mem_cs_n_out,
  output logic                           mem_oe_n_out,
  output logic [`AMWT_ADDR_W-1:0]        mem_addr_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // The wait pin and the read data come from outside the clock domain.
  logic                     wait_s1_reg;
  logic                     wait_s2_reg;
  logic [`AMWT_DATA_W-1:0]  data_s1_reg;
  logic [`AMWT_DATA_W-1:0]  data_s2_reg;

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wait_s1_reg <= 1'b0;
      wait_s2_reg <= 1'b0;
      data_s1_reg <= `AMWT_ZERO_DATA;
      data_s2_reg <= `AMWT_ZERO_DATA;
    end
    else
    begin
      wait_s1_reg <= mem_wait_in;
      wait_s2_reg <= wait_s1_reg;
      data_s1_reg <= mem_data_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Access engine
  // ----------------------------------------------------------------
  amwt_err_if err_if ();

  amwt_pkg::amwt_state_t      state_reg;
  amwt_pkg::amwt_state_t      state_next;
  logic [`AMWT_WAIT_W-1:0]    cnt_reg;
  logic [`AMWT_WAIT_W-1:0]    cnt_next;
  logic [`AMWT_CS_W-1:0]      cs_reg;
  logic [`AMWT_CS_W-1:0]      cs_next;
  logic                       ext_reg;
  logic                       ext_next;
  logic [`AMWT_ADDR_W-1:0]    addr_reg;
  logic [`AMWT_ADDR_W-1:0]    addr_next;
  logic                       done_reg;
  logic                       done_next;
  logic [`AMWT_DATA_W-1:0]    rdata_reg;
  logic [`AMWT_DATA_W-1:0]    rdata_next;
  logic                       async_done;
  logic                       timed_out;
  logic                       busy;

  assign busy = (state_reg != amwt_pkg::AMWT_IDLE) || done_reg;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cs_next    = cs_reg;
    ext_next   = ext_reg;
    addr_next  = addr_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    async_done = 1'b0;
    timed_out  = 1'b0;
    unique case (state_reg)
      amwt_pkg::AMWT_IDLE:
      begin
        if (req_in && !busy)
        begin
          if (req_kind_in == amwt_pkg::AMWT_KIND_OWN)
          begin
            // The error flag is left untouched by own-register reads.
            done_next  = 1'b1;
            rdata_next = own_rdata_in;
          end
          else if (req_kind_in == amwt_pkg::AMWT_KIND_ASYNC)
          begin
            cs_next    = req_cs_in;
            // Mode is latched per access, so clearing it takes effect
            // on the next access to that chip select.
            ext_next   = ext_wait_en_in[req_cs_in];
            addr_next  = req_addr_in;
            cnt_next   = `AMWT_SETUP_CYC;
            state_next = amwt_pkg::AMWT_SETUP;
          end
        end
        if (sdram_done_in)
        begin
          done_next  = 1'b1;
          rdata_next = sdram_rdata_in;
        end
      end
      amwt_pkg::AMWT_SETUP:
      begin
        cnt_next = cnt_reg - `AMWT_ONE_CYC;
        if (cnt_reg == `AMWT_ONE_CYC)
        begin
          cnt_next   = `AMWT_STROBE_CYC;
          state_next = amwt_pkg::AMWT_STROBE;
        end
      end
      amwt_pkg::AMWT_STROBE:
      begin
        cnt_next = cnt_reg - `AMWT_ONE_CYC;
        if (cnt_reg == `AMWT_ONE_CYC)
        begin
          if (ext_reg && wait_s2_reg)
          begin
            cnt_next   = `AMWT_WAIT_W'(0);
            state_next = amwt_pkg::AMWT_WAITX;
          end
          else
          begin
            async_done = 1'b1;
            done_next  = 1'b1;
            rdata_next = data_s2_reg;
            state_next = amwt_pkg::AMWT_IDLE;
          end
        end
      end
      amwt_pkg::AMWT_WAITX:
      begin
        if (!wait_s2_reg)
        begin
          async_done = 1'b1;
          done_next  = 1'b1;
          rdata_next = data_s2_reg;
          state_next = amwt_pkg::AMWT_IDLE;
        end
        else if (cnt_reg >= max_wait_in)
        begin
          // Wait still active once the count reaches the maximum count.
          async_done = 1'b1;
          timed_out  = 1'b1;
          done_next  = 1'b1;
          rdata_next = `AMWT_ZERO_DATA;
          state_next = amwt_pkg::AMWT_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg + `AMWT_ONE_CYC;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= amwt_pkg::AMWT_IDLE;
      cnt_reg   <= `AMWT_WAIT_W'(0);
      cs_reg    <= `AMWT_CS_W'(0);
      ext_reg   <= 1'b0;
      addr_reg  <= `AMWT_ADDR_W'(0);
      done_reg  <= 1'b0;
      rdata_reg <= `AMWT_ZERO_DATA;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cs_reg    <= cs_next;
      ext_reg   <= ext_next;
      addr_reg  <= addr_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Error tracker and outputs
  // ----------------------------------------------------------------
  assign err_if.async_done = async_done;
  assign err_if.timed_out  = timed_out;
  assign err_if.sdram_done = sdram_done_in;

  amwt_err_track u_err
  (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .err_if     (err_if)
  );

  logic active;
  assign active = (state_reg != amwt_pkg::AMWT_IDLE);

  assign done_out        = done_reg;
  assign rdata_out       = rdata_reg;
  assign timeout_err_out = err_if.err;
  assign mem_cs_n_out    = active ? ~(`AMWT_NUM_CS'(1) << cs_reg)
                                  : {`AMWT_NUM_CS{1'b1}};
  assign mem_oe_n_out    = !(state_reg == amwt_pkg::AMWT_STROBE ||
                             state_reg == amwt_pkg::AMWT_WAITX);
  assign mem_addr_out    = addr_reg;

endmodule

`default_nettype wire

// [tb/amwt_assertions.sv]
/* Checker for amwt_top, bound to every instance.
   Assumes the constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "amwt_params.svh"
module amwt_assertions
(
  input wire logic                    sys_clk_in,
  input wire logic                    rstn_in,
  input wire logic                    req_in,
  input wire logic [1:0]              req_kind_in,
  input wire logic [`AMWT_NUM_CS-1:0] ext_wait_en_in,
  input wire logic [`AMWT_WAIT_W-1:0] max_wait_in,
  input wire logic [`AMWT_DATA_W-1:0] own_rdata_in,
  input wire logic                    sdram_done_in,
  input wire logic                    mem_wait_in,
  input wire logic                    done_out,
  input wire logic [`AMWT_DATA_W-1:0] rdata_out,
  input wire logic                    timeout_err_out,
  input wire logic [`AMWT_NUM_CS-1:0] mem_cs_n_out,
  input wire logic                    mem_oe_n_out
);
  logic [8:0]              wcnt_reg;
  logic [`AMWT_NUM_CS-1:0] cs_reg;
  logic                    idle_reg;
  // ----------------
  // Helpers
  // ----------------
  // Wait is counted from the start of each access, so the bound on it
  // is a lower limit only; the sync lag makes it loose by design.
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      wcnt_reg <= 9'h000;
      cs_reg   <= {`AMWT_NUM_CS{1'b0}};
      idle_reg <= 1'b1;
    end
    else
    begin
      idle_reg <= &mem_cs_n_out;
      if (!(&mem_cs_n_out))
        cs_reg <= ~mem_cs_n_out;
      if (idle_reg && !(&mem_cs_n_out))
        wcnt_reg <= 9'h000;
      else if (mem_wait_in && wcnt_reg != 9'h1FF)
        wcnt_reg <= wcnt_reg + 9'h001;
    end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_zero_data: assert property ($rose(timeout_err_out) |->
    rdata_out == `AMWT_ZERO_DATA) else $error("timeout data not zero");
  chk_err_hold: assert property ($fell(timeout_err_out) |->
    done_out || $past(done_out) || $past(sdram_done_in) ||
    $past(sdram_done_in, 2)) else $error("error cleared without cause");
  chk_wait_count: assert property ($rose(timeout_err_out) |->
    wcnt_reg > {1'b0, max_wait_in}) else $error("timeout too early");
  chk_cs_mode: assert property ($rose(timeout_err_out) |->
    |(cs_reg & ext_wait_en_in)) else $error("timeout off extended cs");
  chk_done_bound: assert property ($fell(&mem_cs_n_out) |->
    ##[1:300] done_out) else $error("access never completed");
  // An SDRAM completion also pulses done, so only a taken request counts.
  chk_own_read: assert property (done_out && $past(&mem_cs_n_out) &&
    $past(req_in) && !$past(sdram_done_in) &&
    $past(req_kind_in) == 2'h2 |-> rdata_out == $past(own_rdata_in) &&
    $stable(timeout_err_out)) else $error("own read data or error");
  chk_oe_setup: assert property ($fell(&mem_cs_n_out) |->
    mem_oe_n_out ##2 !mem_oe_n_out) else $error("output enable timing");
endmodule
bind amwt_top amwt_assertions chk_u (.*);
`default_nettype wire

// [tb/amwt_mem_model.sv]
/* Asynchronous memory with a wait output.
   Assumes the constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "amwt_params.svh"
module amwt_mem_model
(
  input  wire logic                    sys_clk_in,
  input  wire logic [`AMWT_NUM_CS-1:0] mem_cs_n_in,
  input  wire logic [`AMWT_ADDR_W-1:0] mem_addr_in,
  input  wire logic                    hang_in,
  input  wire logic [3:0]              slow_in,
  output logic [`AMWT_DATA_W-1:0]      mem_data_out,
  output logic                         mem_wait_out
);
  int                      cnt = 0;
  logic                    sel;
  logic [`AMWT_DATA_W-1:0] data_q = 32'h0000_0000;
  logic                    wait_q = 1'b0;
  assign sel = ~&mem_cs_n_in;
  assign mem_data_out = data_q;
  assign mem_wait_out = wait_q;
  // A released data bus shows the inverse of its last value each cycle, so the last
  // word returns every other cycle; wait has a pull-down and reads low when idle.
  always @(posedge sys_clk_in)
  begin
    cnt <= sel ? cnt + 1 : 0;
    wait_q <= sel && (hang_in || cnt < slow_in);
    data_q <= sel ? {8'hA5, mem_addr_in} : ~data_q;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
/* Self-checking bench for amwt_top with a memory model.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "amwt_params.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb;
  logic        clk = 1'b0, rstn, req, sdone, hang, exp_err;
  logic [1:0]  kind, cs;
  logic [3:0]  ext, slow;
  logic [7:0]  maxw;
  logic [23:0] addr, maddr;
  logic [31:0] own, mdata, rdata, exp_d, sdata;
  logic [3:0]  cs_n;
  logic        done, err, mwait;
  int          error_cnt = 0, n_compared = 0;
  amwt_top dut_u (.sys_clk_in(clk), .rstn_in(rstn), .req_in(req),
    .req_kind_in(kind), .req_cs_in(cs), .req_addr_in(addr),
    .ext_wait_en_in(ext), .max_wait_in(maxw), .own_rdata_in(own),
    .sdram_done_in(sdone), .sdram_rdata_in(sdata), .mem_data_in(mdata),
    .mem_wait_in(mwait), .done_out(done), .rdata_out(rdata),
    .timeout_err_out(err), .mem_cs_n_out(cs_n), .mem_oe_n_out(),
    .mem_addr_out(maddr));
  amwt_mem_model mem_u (.sys_clk_in(clk), .mem_cs_n_in(cs_n),
    .mem_addr_in(maddr), .hang_in(hang), .slow_in(slow),
    .mem_data_out(mdata), .mem_wait_out(mwait));
  always #4 clk = ~clk;
  task automatic results;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One read, held until done; the reference result is worked out here.
  task automatic acc(input logic [1:0] k, input logic [1:0] c);
    logic [23:0] a;
    logic [31:0] o;
    int          i;
    a = 24'($urandom);
    o = $urandom;
    @(posedge clk);
    kind <= k;
    cs <= c;
    addr <= a;
    own <= o;
    req <= 1'b1;
    i = 0;
    @(posedge clk);
    while (done !== 1'b1 && i < 400)
    begin
      @(posedge clk);
      i++;
    end
    req <= 1'b0;
    if (i >= 400)
    begin
      error_cnt++;
      results;
    end
    else
    begin
      if (k == 2'h2)
        exp_d = o;
      else if (ext[c] && hang)
      begin
        exp_d = 32'h0;
        exp_err = 1'b1;
      end
      else
      begin
        exp_d = {8'hA5, a};
        exp_err = 1'b0;
      end
      `CHK("rdata", exp_d, rdata)
      `CHK("err", exp_err, err)
    end
  endtask
  initial
  begin
    {rstn, req, sdone, hang, exp_err, kind, cs} = 9'h000;
    {ext, slow, maxw, addr, own, sdata} = 104'h0;
    ext = 4'h2;
    maxw = 8'h14;
    void'($urandom(56));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    acc(2'h0, 2'h0);
    slow <= 4'hC;
    acc(2'h0, 2'h1);
    hang <= 1'b1;
    maxw <= 8'($urandom_range(9, 2));
    acc(2'h0, 2'h1);
    acc(2'h2, 2'h0);
    @(posedge clk);
    sdone <= 1'b1;
    sdata <= $urandom;
    @(posedge clk);
    sdone <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("err", 1'b0, err)
    `CHK("sdram rdata", sdata, rdata)
    exp_err = 1'b0;
    acc(2'h0, 2'h1);
    acc(2'h0, 2'h0);
    acc(2'h0, 2'h1);
    ext <= 4'h0;
    acc(2'h0, 2'h1);
    results;
  end
endmodule
`default_nettype wire
